/* File: als_flags_pkg.sv */
// Constants for the light sensor flag and interrupt block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
// Functional notes
// [RULE_01] Overflow flag set on overflowing conversion, cleared otherwise, updated every measurement.
// [RULE_02] Fixed range may flag overflow though the result is below full-scale.
// [RULE_03] Auto range flags overflow only beyond the largest supported full-scale.
// [RULE_04] Auto overflow below top range aborts, steps range up, restarts, then flags.
// [RULE_05] Conversion-ready flag set when each conversion finishes.
// [RULE_06] Ready flag cleared by config read or non-shutdown write; shutdown write keeps it.
// [RULE_07] High flag set after result exceeds high limit for fault-count measurements.
// [RULE_08] Low flag set after result falls below low limit for fault-count measurements.
// [RULE_09] Latch bit 0: pin and flags follow the current comparison directly.
// [RULE_10] Latch bit 1 (reset): pin and flags held until a user clearing event.
// [RULE_11] Polarity 0 (reset): interrupt pulls the pin low.
// [RULE_12] Polarity 1: interrupt releases the pin, pull-up makes it high.
// [RULE_13] Mask bit 1 with fixed range reports result exponent as zero.
// [RULE_14] Masking affects only the read result; comparisons use the unmasked result.
// [RULE_15] Fault-count codes 00,01,10,11 need 1,2,4,8 consecutive faults; default 00.
// [RULE_16] Entering shutdown leaves ready, high, low flags and the pin unchanged.
// [RULE_17] Range code 1100b selects auto ranging; chosen range shows in result exponent.
// [RULE_18] Writes to read-only indicator bits are ignored.
package als_flags_pkg;

  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [7:0]  ADDR_RESULT      = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_LOW_LIMIT   = 8'h08;
  localparam logic [7:0]  ADDR_HIGH_LIMIT  = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h14;

  // ********************************
  // Control/status field positions
  // ********************************
  localparam int RANGE_LSB   = 12;
  localparam int CONV_TIME_B = 11;
  localparam int MODE_LSB    = 9;
  localparam int OVF_B       = 8;
  localparam int READY_B     = 7;
  localparam int HIGH_B      = 6;
  localparam int LOW_B       = 5;
  localparam int LATCH_B     = 4;
  localparam int POL_B       = 3;
  localparam int MASK_B      = 2;
  localparam int FC_LSB      = 0;

  localparam logic [3:0]  RANGE_AUTO  = 4'hc;
  localparam logic [3:0]  RANGE_MAX   = 4'hb;
  localparam logic [1:0]  MODE_SHUT   = 2'h0;
  localparam logic [1:0]  MODE_SINGLE = 2'h1;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [3:0]  RST_RANGE     = 4'hc;
  localparam logic        RST_CONV_TIME = 1'b1;
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic        RST_LATCH     = 1'b1;
  localparam logic        RST_POL       = 1'b0;
  localparam logic        RST_MASK      = 1'b0;
  localparam logic [1:0]  RST_FC        = 2'h0;
  localparam logic [15:0] RST_LOW_LIM   = 16'hc000;
  localparam logic [15:0] RST_HIGH_LIM  = 16'hbfff;

  // Interrupt status bits: 0 ready, 1 high, 2 low, 3 overflow
  localparam int IRQ_BITS = 4;

endpackage

/* File: als_flags.sv */
// Flag, interrupt and range stepping logic of an ambient light sensor.
// Assumes an external converter delivering one result per conv_done pulse.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module als_flags
  import als_flags_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Converter side
  output logic             conv_start,
  output logic [3:0]       conv_range,
  output logic             conv_long,
  input  wire logic        conv_done,
  input  wire logic        conv_overload,
  input  wire logic [11:0] conv_mantissa,
  // Open-drain interrupt pin
  output logic             int_pin_o,
  output logic             int_pin_oe,
  // Bus interrupt
  output logic             irq
);

  // ********************************
  // Reset synchroniser
  // ********************************
  logic rst_meta_ff, rst_sync_ff;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rst_n = rst_sync_ff;

  // ********************************
  // Bus decode
  // ********************************
  logic        wr_en, rd_en, hit;
  assign pready  = 1'b1;
  assign hit     = (paddr == ADDR_RESULT) || (paddr == ADDR_CTRL_STATUS) || (paddr == ADDR_LOW_LIMIT) ||
                   (paddr == ADDR_HIGH_LIMIT) || (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK);
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && hit;
  assign rd_en   = psel && penable && !pwrite && hit;

  logic wr_cfg, rd_cfg;
  assign wr_cfg = wr_en && (paddr == ADDR_CTRL_STATUS);
  assign rd_cfg = rd_en && (paddr == ADDR_CTRL_STATUS);

  // ********************************
  // Writable control fields
  // ********************************
  logic [3:0]  range_number_ff;
  logic        conv_time_ff;
  logic        latch_sel_ff, irq_polarity_ff, exponent_mask_ff;
  logic [1:0]  fault_count_ff;
  logic [15:0] low_limit_ff, high_limit_ff;
  logic [IRQ_BITS-1:0] irq_mask_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      range_number_ff  <= RST_RANGE;
      conv_time_ff     <= RST_CONV_TIME;
      latch_sel_ff     <= RST_LATCH;
      irq_polarity_ff  <= RST_POL;
      exponent_mask_ff <= RST_MASK;
      fault_count_ff   <= RST_FC;
      low_limit_ff     <= RST_LOW_LIM;
      high_limit_ff    <= RST_HIGH_LIM;
      irq_mask_ff      <= '0;
    end else if (wr_en) begin
      // Indicator bits 8:5 are not stored from the bus [RULE_18]
      if (paddr == ADDR_CTRL_STATUS) begin
        range_number_ff  <= pwdata[RANGE_LSB +: 4];
        conv_time_ff     <= pwdata[CONV_TIME_B];
        latch_sel_ff     <= pwdata[LATCH_B];
        irq_polarity_ff  <= pwdata[POL_B];
        exponent_mask_ff <= pwdata[MASK_B];
        fault_count_ff   <= pwdata[FC_LSB +: 2];
      end
      if (paddr == ADDR_LOW_LIMIT)  low_limit_ff  <= pwdata[15:0];
      if (paddr == ADDR_HIGH_LIMIT) high_limit_ff <= pwdata[15:0];
      if (paddr == ADDR_IRQ_MASK)   irq_mask_ff   <= pwdata[IRQ_BITS-1:0];
    end
  end

  // ********************************
  // Conversion sequencer
  // ********************************
  typedef enum logic [1:0] {IDLE, RUN} seq_state_t;
  seq_state_t  state_ff;
  logic [1:0]  mode_ff;
  logic [3:0]  active_range_ff;
  logic        conv_start_ff;
  logic        step_up, finished, auto_mode;

  assign auto_mode = (range_number_ff == RANGE_AUTO); // [RULE_17]
  // Auto-range overload below the top range restarts on the next range instead of finishing [RULE_04]
  assign step_up  = (state_ff == RUN) && conv_done && conv_overload && auto_mode &&
                    (active_range_ff != RANGE_MAX);
  assign finished = (state_ff == RUN) && conv_done && !step_up;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= RST_MODE;
    end else if (wr_cfg) begin
      mode_ff <= pwdata[MODE_LSB +: 2];
    end else if (finished && mode_ff == MODE_SINGLE) begin
      mode_ff <= MODE_SHUT;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff        <= IDLE;
      active_range_ff <= RANGE_MAX;
      conv_start_ff   <= 1'b0;
    end else begin
      conv_start_ff <= 1'b0;
      case (state_ff)
        IDLE: begin
          if (mode_ff != MODE_SHUT) begin
            state_ff        <= RUN;
            conv_start_ff   <= 1'b1;
            active_range_ff <= auto_mode ? active_range_ff : range_number_ff;
          end
        end
        RUN: begin
          if (step_up) begin
            active_range_ff <= active_range_ff + 4'h1; // [RULE_04]
            conv_start_ff   <= 1'b1;
          end else if (finished) begin
            state_ff <= IDLE;
          end
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  assign conv_start = conv_start_ff;
  assign conv_range = active_range_ff;
  assign conv_long  = conv_time_ff;

  // ********************************
  // Result and comparison
  // ********************************
  logic [15:0] result_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= '0;
    end else if (finished) begin
      result_ff <= {active_range_ff, conv_mantissa}; // [RULE_17]
    end
  end

  // Compare in lux: mantissa shifted by exponent, 27 bits covers 4095 << 15
  function automatic logic [26:0] to_lux(input logic [15:0] v);
    to_lux = 27'(v[11:0]) << v[15:12];
  endfunction

  logic [26:0] new_lux;
  logic        above, below;
  assign new_lux = to_lux({active_range_ff, conv_mantissa});
  // Unmasked result used here, never the read view [RULE_14]
  assign above = new_lux > to_lux(high_limit_ff);
  assign below = new_lux < to_lux(low_limit_ff);

  // ********************************
  // Fault counting
  // ********************************
  logic [3:0] high_cnt_ff, low_cnt_ff;
  logic [3:0] need;
  always_comb begin
    case (fault_count_ff) // [RULE_15]
      2'h0:    need = 4'h1;
      2'h1:    need = 4'h2;
      2'h2:    need = 4'h4;
      default: need = 4'h8;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt_ff <= '0;
      low_cnt_ff  <= '0;
    end else if (finished) begin
      high_cnt_ff <= above ? ((high_cnt_ff == 4'hf) ? high_cnt_ff : high_cnt_ff + 4'h1) : 4'h0;
      low_cnt_ff  <= below ? ((low_cnt_ff == 4'hf) ? low_cnt_ff : low_cnt_ff + 4'h1) : 4'h0;
    end
  end

  logic high_hit, low_hit;
  assign high_hit = above && ((high_cnt_ff + 4'h1) >= need); // [RULE_07]
  assign low_hit  = below && ((low_cnt_ff + 4'h1) >= need);  // [RULE_08]

  // ********************************
  // Indicator flags
  // ********************************
  logic overflow_indicator_ff, conversion_ready_indicator_ff;
  logic high_threshold_indicator_ff, low_threshold_indicator_ff;
  logic user_clear;

  // Clearing event in latched mode: a read of the control register
  assign user_clear = rd_cfg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overflow_indicator_ff <= 1'b0;
    end else if (finished) begin
      // Fixed range reports any overload, auto only overload on the top range [RULE_01] [RULE_02] [RULE_03]
      overflow_indicator_ff <= conv_overload;
    end
  end

  // Set wins over clear; shutdown writes do not clear [RULE_05] [RULE_06] [RULE_16]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conversion_ready_indicator_ff <= 1'b0;
    end else if (finished) begin
      conversion_ready_indicator_ff <= 1'b1;
    end else if (rd_cfg || (wr_cfg && pwdata[MODE_LSB +: 2] != MODE_SHUT)) begin
      conversion_ready_indicator_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_threshold_indicator_ff <= 1'b0;
      low_threshold_indicator_ff  <= 1'b0;
    end else if (!latch_sel_ff) begin
      // Transparent: follow each new comparison [RULE_09]
      if (finished) begin
        high_threshold_indicator_ff <= high_hit ? 1'b1 : (above ? high_threshold_indicator_ff : 1'b0);
        low_threshold_indicator_ff  <= low_hit ? 1'b1 : (below ? low_threshold_indicator_ff : 1'b0);
      end
    end else begin
      // Latched: hold until read, a new hit wins over the clear [RULE_10]
      if (finished && high_hit) begin
        high_threshold_indicator_ff <= 1'b1;
      end else if (user_clear) begin
        high_threshold_indicator_ff <= 1'b0;
      end
      if (finished && low_hit) begin
        low_threshold_indicator_ff <= 1'b1;
      end else if (user_clear) begin
        low_threshold_indicator_ff <= 1'b0;
      end
    end
  end

  // ********************************
  // Interrupt pin
  // ********************************
  logic pin_active;
  assign pin_active = high_threshold_indicator_ff || low_threshold_indicator_ff;
  assign int_pin_o  = 1'b0;
  // Pin is only ever pulled low; high comes from the external pull-up [RULE_11] [RULE_12]
  assign int_pin_oe = irq_polarity_ff ? !pin_active : pin_active;

  // ********************************
  // Bus interrupt status
  // ********************************
  logic [IRQ_BITS-1:0] irq_status_ff, irq_event;
  assign irq_event = {finished && conv_overload, finished && low_hit, finished && high_hit, finished};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_ff <= '0;
    end else begin
      for (int i = 0; i < IRQ_BITS; i++) begin
        if (irq_event[i]) begin
          irq_status_ff[i] <= 1'b1;
        end else if (wr_en && paddr == ADDR_IRQ_STATUS && pwdata[i]) begin
          irq_status_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // ********************************
  // Read data
  // ********************************
  logic [15:0] ctrl_view, result_view;
  assign ctrl_view = {range_number_ff, conv_time_ff, mode_ff, overflow_indicator_ff,
                      conversion_ready_indicator_ff, high_threshold_indicator_ff,
                      low_threshold_indicator_ff, latch_sel_ff, irq_polarity_ff,
                      exponent_mask_ff, fault_count_ff};
  // Masked exponent only in the read view [RULE_13] [RULE_14]
  assign result_view = (exponent_mask_ff && !auto_mode) ? {4'h0, result_ff[11:0]} : result_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_RESULT:      prdata <= {16'h0, result_view};
        ADDR_CTRL_STATUS: prdata <= {16'h0, ctrl_view};
        ADDR_LOW_LIMIT:   prdata <= {16'h0, low_limit_ff};
        ADDR_HIGH_LIMIT:  prdata <= {16'h0, high_limit_ff};
        ADDR_IRQ_STATUS:  prdata <= {28'h0, irq_status_ff};
        ADDR_IRQ_MASK:    prdata <= {28'h0, irq_mask_ff};
        default:          prdata <= '0;
      endcase
    end
  end

endmodule

/* File: als_conv_model.sv */
// Converter model facing the flag block: one result per conv_start.
// Assumes the bench supplies lag, overload and mantissa before each start.
`timescale 1ns/1ns
module als_conv_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Block side
  input  wire logic        conv_start,
  output logic             conv_done,
  output logic             conv_overload,
  output logic [11:0]      conv_mantissa,
  // Bench side
  input  wire logic [2:0]  lag,
  input  wire logic        ovl,
  input  wire logic [11:0] mant
);
  logic [2:0] cnt_ff;
  logic       busy_ff;
  // Overload and mantissa toggle while idle so stale data never looks valid
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      conv_done <= 1'b0;
      conv_overload <= 1'b0;
      conv_mantissa <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= lag;
      end else if (busy_ff && cnt_ff == 3'h0) begin
        busy_ff <= 1'b0;
        conv_done <= 1'b1;
        conv_overload <= ovl;
        conv_mantissa <= mant;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 3'h1;
      end else begin
        conv_overload <= ~conv_overload;
        conv_mantissa <= ~conv_mantissa;
      end
    end
  end
endmodule

/* File: als_flags_properties.sv */
// Port-level checker for the flag and interrupt block.
// Assumes aligned APB addresses only.
`timescale 1ns/1ns
module als_flags_properties
  import als_flags_pkg::*;
(
  // Clock, reset and APB
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Converter, pin and interrupt
  input wire logic        conv_start,
  input wire logic [3:0]  conv_range,
  input wire logic        conv_done,
  input wire logic        int_pin_o,
  input wire logic        int_pin_oe,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [3:0] rng_ff;
  logic [3:0] mask_ff;
  logic       evt_ff;
  logic       mz_ff;
  logic       wr;
  assign wr = psel & penable & pwrite;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rng_ff <= RST_RANGE;
      mask_ff <= 4'h0;
      evt_ff <= 1'b0;
      mz_ff <= 1'b1;
    end else begin
      evt_ff <= conv_done | (psel & penable);
      mz_ff <= mask_ff == 4'h0;
      if (wr && paddr == ADDR_CTRL_STATUS) rng_ff <= pwdata[15:12];
      if (wr && paddr == ADDR_IRQ_MASK) mask_ff <= pwdata[3:0];
    end
  end
  a_zero_wait: assert property (psel && penable |-> pready) else $error("pready low in access");
  a_unmapped_err: assert property (psel && penable && paddr > ADDR_IRQ_MASK |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= ADDR_IRQ_MASK |-> !pslverr) else $error("mapped refused");
  a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start longer than one cycle");
  a_start_mode: assert property (wr && paddr == ADDR_CTRL_STATUS && pwdata[10:9] != MODE_SHUT |-> ##[1:3] conv_start)
    else $error("no start after mode write");
  a_fixed_range: assert property (conv_start && rng_ff != RANGE_AUTO |-> conv_range == rng_ff)
    else $error("wrong fixed range");
  a_auto_step: assert property (conv_start && rng_ff == RANGE_AUTO && $past(conv_done) |->
    conv_range == $past(conv_range) + 4'h1 && conv_range <= RANGE_MAX) else $error("auto range did not step up");
  a_pin_drive: assert property (int_pin_o == 1'b0) else $error("pin driven high");
  a_pin_cause: assert property ($changed(int_pin_oe) |-> evt_ff || $past(evt_ff))
    else $error("pin moved without cause");
  a_irq_cause: assert property ($rose(irq) |-> evt_ff || $past(evt_ff)) else $error("irq rose without cause");
  a_irq_masked: assert property (mask_ff == 4'h0 && mz_ff |-> !irq) else $error("masked irq high");
endmodule
bind als_flags als_flags_properties u_props (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .conv_start(conv_start), .conv_range(conv_range), .conv_done(conv_done), .int_pin_o(int_pin_o),
  .int_pin_oe(int_pin_oe), .irq(irq));

/* File: light_sensor_flags_interrupt_config_test.sv */
// Self-checking bench for the flag block with a converter model.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ns
module light_sensor_flags_interrupt_config_test
  import als_flags_pkg::*;
;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, conv_start, conv_long, conv_done, conv_overload;
  logic int_pin_o, int_pin_oe, irq, ovl, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, m;
  logic [3:0] conv_range, r;
  logic [11:0] conv_mantissa, mant;
  logic [2:0] lag;
  int mismatches, checks, cyc, i, k;
  als_flags DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .conv_start(conv_start),
    .conv_range(conv_range), .conv_long(conv_long), .conv_done(conv_done), .conv_overload(conv_overload),
    .conv_mantissa(conv_mantissa), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .irq(irq));
  als_conv_model u_conv (.clock(clock), .rst_b(rst_b), .conv_start(conv_start), .conv_done(conv_done),
    .conv_overload(conv_overload), .conv_mantissa(conv_mantissa), .lag(lag), .ovl(ovl), .mant(mant));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] cw(logic [3:0] rn, logic [1:0] md, logic l, logic p, logic x, logic [1:0] f);
    return {16'h0, rn, 1'b0, md, 4'h0, l, p, x, f};
  endfunction
  function automatic logic [31:0] st(logic o, logic c, logic h, logic l);
    return {23'h0, o, c, h, l, 5'h0};
  endfunction
  task automatic final_report();
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Single-shot conversion; leaves the flags settled
  task automatic conv(logic [3:0] rn, logic l, logic p, logic x, logic [1:0] f, logic o, logic [11:0] v);
    logic [31:0] lg;
    lg = xs();
    lag <= lg[2:0];
    ovl <= o;
    mant <= v;
    apb(1'b1, ADDR_CTRL_STATUS, cw(rn, MODE_SINGLE, l, p, x, f));
    // An aborted auto-range result restarts one cycle later; wait past every step
    do begin
      while (conv_done !== 1'b1) @(posedge clock);
      @(posedge clock);
    end while (conv_start === 1'b1);
  endtask
  initial begin
    clock = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    lag = 0; ovl = 0; mant = 0; seed = 32'h46; mismatches = 0; checks = 0; cyc = 0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    // ********************************
    // Reset values and refusal
    // ********************************
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("ctrl_reset", 32'h0000c810, rd);
    apb(1'b0, ADDR_HIGH_LIMIT, 32'h0);
    chk("high_reset", {16'h0, RST_HIGH_LIM}, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    apb(1'b1, ADDR_IRQ_MASK, 32'hf);
    // ********************************
    // Random fixed-range results, overflow alternating
    // ********************************
    for (i = 0; i < 6; i++) begin
      m = xs();
      r = (m[15:12] > RANGE_MAX) ? 4'h5 : m[15:12];
      conv(r, 1'b0, 1'b0, m[16], 2'h0, i[0], m[11:0]);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk("result", {16'h0, m[16] ? 4'h0 : r, m[11:0]}, rd);
      apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
      chk("ctrl", cw(r, MODE_SHUT, 1'b0, 1'b0, m[16], 2'h0) | st(i[0], 1'b1, 1'b0, 1'b0), rd);
      apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
      chk("ready_clr", 32'h0, rd & st(1'b0, 1'b1, 1'b0, 1'b0));
      apb(1'b1, ADDR_IRQ_STATUS, 32'hf);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    // Shutdown write with read-only bits set keeps the ready flag
    conv(4'h3, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 12'h001);
    apb(1'b1, ADDR_CTRL_STATUS, cw(4'h3, MODE_SHUT, 1'b0, 1'b0, 1'b0, 2'h0) | 32'h1e0);
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("shut_ready", cw(4'h3, MODE_SHUT, 1'b0, 1'b0, 1'b0, 2'h0) | st(1'b0, 1'b1, 1'b0, 1'b0), rd);
    // ********************************
    // Fault counts 1, 2, 4, 8 on the pin
    // ********************************
    apb(1'b1, ADDR_HIGH_LIMIT, 32'h0);
    for (i = 0; i < 4; i++) begin
      conv(4'h2, 1'b0, 1'b0, 1'b0, i[1:0], 1'b0, 12'h000);
      for (k = 1; k <= (1 << i); k++) begin
        m = xs();
        conv(4'h2, 1'b0, 1'b0, 1'b0, i[1:0], 1'b0, m[11:0] | 12'h001);
        chk("fault_pin", {31'h0, k == (1 << i)}, {31'h0, int_pin_oe});
      end
    end
    apb(1'b1, ADDR_CTRL_STATUS, cw(4'h2, MODE_SHUT, 1'b0, 1'b1, 1'b0, 2'h3));
    chk("pol_high", 32'h0, {31'h0, int_pin_oe});
    conv(4'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 12'h000);
    chk("transp_clr", 32'h0, {31'h0, int_pin_oe});
    // Latched flag holds until a status read
    conv(4'h2, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 12'h005);
    conv(4'h2, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 12'h000);
    chk("latch_hold", 32'h1, {31'h0, int_pin_oe});
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("latch_flag", st(1'b0, 1'b1, 1'b1, 1'b0), rd & st(1'b1, 1'b1, 1'b1, 1'b1));
    chk("latch_clr", 32'h0, {31'h0, int_pin_oe});
    // Masked exponent still compares in full: 0x101<<3 above 0x100<<3
    apb(1'b1, ADDR_HIGH_LIMIT, 32'h3100);
    conv(4'h3, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 12'h101);
    chk("mask_cmp", 32'h1, {31'h0, int_pin_oe});
    // Low threshold: 0x3ff below 0x100<<2
    apb(1'b1, ADDR_HIGH_LIMIT, 32'hbfff);
    apb(1'b1, ADDR_LOW_LIMIT, 32'h2100);
    conv(4'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 12'h3ff);
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("low_flag", st(1'b0, 1'b1, 1'b0, 1'b1), rd & st(1'b1, 1'b1, 1'b1, 1'b1));
    // Auto range overload at the top range; exponent not masked
    m = xs();
    conv(RANGE_AUTO, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, m[11:0]);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("auto_exp", {16'h0, RANGE_MAX, m[11:0]}, rd);
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("auto_ovf", st(1'b1, 1'b0, 1'b0, 1'b0), rd & st(1'b1, 1'b0, 1'b0, 1'b0));
    // Masked interrupt stays low
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_IRQ_STATUS, 32'hf);
    conv(4'h1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 12'h010);
    chk("irq_masked", 32'h0, {31'h0, irq});
    // Continuous mode keeps converting and keeps its mode field
    apb(1'b1, ADDR_CTRL_STATUS, cw(4'h1, 2'h2, 1'b0, 1'b0, 1'b0, 2'h0));
    repeat (2) begin
      while (conv_done !== 1'b1) @(posedge clock);
      @(posedge clock);
    end
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("cont_mode", cw(4'h1, 2'h2, 1'b0, 1'b0, 1'b0, 2'h0) | st(1'b0, 1'b1, 1'b0, 1'b0), rd & ~32'h160);
    final_report();
  end
endmodule
